// ### verilog/cbx_core.sv
`timescale 1ns/1ps
// Functional notes
// - Indirect jump loads pc from pair/index.
// - Call pushes return address, then jumps.
// - Return pops stack top into pc.
// - Both interrupt returns pop pc as plain return; the maskable one also pulses int_return_seen.
// - Loop decrements count, branches if nonzero.
// - Loop displacement is signed, from next instruction.
// - Eight restarts call fixed low targets.
// - Ports addressed by immediate or register.
// - Immediate port: byte low, accumulator high.
// - Indirect port: port register low, count high.
// - Block ports use pointer pair as memory.
// - Block instruction moves at most 256 bytes.
// - Block input: read port, store, step.
// - Block output: read memory, write port, step.
// - Failed condition continues with next instruction.
// - Sixteen-bit targets fetched low byte first.
// - Relative range measured from next instruction address.
module cbx_core (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  output logic                        bus_req,
  output logic                        bus_we,
  output logic                        bus_io,
  output logic [cbx_pkg::AW-1:0]      bus_addr,
  output logic [cbx_pkg::DW-1:0]      bus_wdata,
  input  wire logic                   bus_ack,
  input  wire logic [cbx_pkg::DW-1:0] bus_rdata,
  input  wire logic [cbx_pkg::DW-1:0] flags,
  output logic                        int_return_seen
);
  import cbx_pkg::*;

  // ==========================================================
  // Architectural state
  cbx_state_t  state;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] index_reg_x;
  logic [15:0] index_reg_y;
  logic [15:0] tmp;
  logic [7:0]  op;
  logic [7:0]  regs [NREGS];
  logic [1:0]  idx;
  logic [2:0]  dst;
  logic        ed;
  logic        cont;
  logic        blk;
  logic        hi;
  logic        two;

  logic [15:0] pointer_pair;
  logic [15:0] pointer_pair_step;
  logic [15:0] disp;
  logic [7:0]  b_dec;
  logic        blk_end;

  assign pointer_pair = {regs[REG_H], regs[REG_L]};
  assign pointer_pair_step = op[BLK_DOWN_BIT] ? pointer_pair - ONE16 : pointer_pair + ONE16;
  assign disp = {{8{tmp[7]}}, tmp[7:0]};
  assign b_dec = regs[REG_B] - 8'h01;
  assign blk_end = bus_ack && ((state == S_MEM && !op[BLK_OUT_BIT]) ||
                               (state == S_IO && blk && op[BLK_OUT_BIT]));

  function automatic logic cond_ok(input logic [2:0] cc);
    logic f;
    f = 1'b0;
    case (cc[2:1])
      2'h0:    f = flags[FLAG_Z];
      2'h1:    f = flags[FLAG_C];
      2'h2:    f = flags[FLAG_PV];
      default: f = flags[FLAG_S];
    endcase
    return cc[0] ? f : !f;
  endfunction : cond_ok

  task automatic bus_start(input logic [15:0] a, input logic we,
                           input logic io, input logic [7:0] d);
    bus_req   <= 1'b1;
    bus_addr  <= a;
    bus_we    <= we;
    bus_io    <= io;
    bus_wdata <= d;
  endtask : bus_start

  // Closes one block transfer step and rewinds for the repeat forms while the decremented count is nonzero.
  task automatic blk_finish();
    regs[REG_B] <= b_dec;
    regs[REG_H] <= pointer_pair_step[15:8];
    regs[REG_L] <= pointer_pair_step[7:0];
    if (op[BLK_REP_BIT] && b_dec != ZERO8) begin
      pc <= pc - TWO16;
    end
    state <= S_NEXT;
  endtask : blk_finish

  // ==========================================================
  // Sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state     <= S_NEXT;
      pc        <= PC_RESET;
      sp        <= SP_RESET;
      index_reg_x <= 16'h0000;
      index_reg_y <= 16'h0000;
      tmp       <= 16'h0000;
      op        <= 8'h00;
      idx       <= IDX_NONE;
      dst       <= REG_A;
      ed        <= 1'b0;
      cont      <= 1'b0;
      blk       <= 1'b0;
      hi        <= 1'b0;
      two       <= 1'b0;
      bus_req   <= 1'b0;
      bus_we    <= 1'b0;
      bus_io    <= 1'b0;
      bus_addr  <= 16'h0000;
      bus_wdata <= 8'h00;
      int_return_seen <= 1'b0;
      for (int i = 0; i < NREGS; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      int_return_seen <= 1'b0;
      case (state)
        S_NEXT: begin
          if (!cont) begin
            ed  <= 1'b0;
            idx <= IDX_NONE;
          end
          cont <= 1'b0;
          bus_start(pc, 1'b0, 1'b0, ZERO8);
          state <= S_FETCH;
        end
        S_FETCH: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            op      <= bus_rdata;
            pc      <= pc + ONE16;
            state   <= S_DEC;
          end
        end
        S_DEC: begin
          hi    <= 1'b0;
          two   <= 1'b0;
          state <= S_NEXT;
          if (!ed && idx == IDX_NONE && op == OP_ED) begin
            ed   <= 1'b1;
            cont <= 1'b1;
          end else if (!ed && (op == OP_DD || op == OP_FD)) begin
            idx  <= (op == OP_DD) ? IDX_X : IDX_Y;
            cont <= 1'b1;
          end else if (ed) begin
            if (op == OP_MASKABLE_INTERRUPT_RETURN || op == OP_NMI_RETURN) begin
              int_return_seen <= (op == OP_MASKABLE_INTERRUPT_RETURN);
              bus_start(sp, 1'b0, 1'b0, ZERO8);
              state <= S_POP_L;
            end else if ((op & MASK_CC) == PAT_INC) begin
              blk <= 1'b0;
              dst <= op[5:3];
              bus_start({regs[REG_B], regs[REG_C]}, 1'b0, 1'b1, ZERO8);
              state <= S_IO;
            end else if ((op & MASK_CC) == PAT_OUTC) begin
              blk <= 1'b0;
              bus_start({regs[REG_B], regs[REG_C]}, 1'b1, 1'b1,
                        (op[5:3] == REG_MEM) ? ZERO8 : regs[op[5:3]]);
              state <= S_IO;
            end else if ((op & MASK_BLK) == PAT_BLK) begin
              blk <= 1'b1;
              if (op[BLK_OUT_BIT]) begin
                bus_start(pointer_pair, 1'b0, 1'b0, ZERO8);
                state <= S_MEM;
              end else begin
                bus_start({regs[REG_B], regs[REG_C]}, 1'b0, 1'b1, ZERO8);
                state <= S_IO;
              end
            end
          end else if (op == OP_JP_INDIRECT) begin
            pc <= (idx == IDX_X) ? index_reg_x : (idx == IDX_Y) ? index_reg_y : pointer_pair;
          end else if (op == OP_RET ||
                       ((op & MASK_CC) == PAT_RETCC && cond_ok(op[5:3]))) begin
            bus_start(sp, 1'b0, 1'b0, ZERO8);
            state <= S_POP_L;
          end else if ((op & MASK_CC) == PAT_RST) begin
            tmp <= {ZERO8, op & RST_TGT};
            bus_start(sp - ONE16, 1'b1, 1'b0, pc[15:8]);
            state <= S_PUSH_H;
          end else if ((op & MASK_CC) == PAT_LDN || op == OP_COUNT_DOWN_BRANCH ||
                       op == OP_JR || (op & MASK_JRCC) == PAT_JRCC ||
                       op == OP_IN_IMM || op == OP_OUT_IMM) begin
            bus_start(pc, 1'b0, 1'b0, ZERO8);
            state <= S_IMM;
          end else if ((op & MASK_LDNN) == PAT_LDNN || op == OP_JP ||
                       op == OP_CALL || (op & MASK_CC) == PAT_JPCC ||
                       (op & MASK_CC) == PAT_CALLCC) begin
            two <= 1'b1;
            bus_start(pc, 1'b0, 1'b0, ZERO8);
            state <= S_IMM;
          end
        end
        S_IMM: begin
          if (bus_ack) begin
            pc <= pc + ONE16;
            if (!hi) begin
              tmp[7:0] <= bus_rdata;
            end else begin
              tmp[15:8] <= bus_rdata;
            end
            if (two && !hi) begin
              hi <= 1'b1;
              bus_start(pc + ONE16, 1'b0, 1'b0, ZERO8);
            end else begin
              bus_req <= 1'b0;
              state   <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          state <= S_NEXT;
          if ((op & MASK_CC) == PAT_LDN && op[5:3] != REG_MEM) begin
            regs[op[5:3]] <= tmp[7:0];
          end else if ((op & MASK_LDNN) == PAT_LDNN) begin
            case (op[5:4])
              2'h0: {regs[REG_B], regs[REG_C]} <= tmp;
              2'h1: {regs[3'h2], regs[3'h3]} <= tmp;
              2'h2: begin
                if (idx == IDX_X) begin
                  index_reg_x <= tmp;
                end else if (idx == IDX_Y) begin
                  index_reg_y <= tmp;
                end else begin
                  {regs[REG_H], regs[REG_L]} <= tmp;
                end
              end
              default: sp <= tmp;
            endcase
          end else if (op == OP_COUNT_DOWN_BRANCH) begin
            regs[REG_B] <= b_dec;
            if (b_dec != ZERO8) begin
              pc <= pc + disp;
            end
          end else if (op == OP_JR ||
                       ((op & MASK_JRCC) == PAT_JRCC && cond_ok({1'b0, op[4:3]}))) begin
            pc <= pc + disp;
          end else if (op == OP_JP ||
                       ((op & MASK_CC) == PAT_JPCC && cond_ok(op[5:3]))) begin
            pc <= tmp;
          end else if (op == OP_CALL ||
                       ((op & MASK_CC) == PAT_CALLCC && cond_ok(op[5:3]))) begin
            bus_start(sp - ONE16, 1'b1, 1'b0, pc[15:8]);
            state <= S_PUSH_H;
          end else if (op == OP_IN_IMM || op == OP_OUT_IMM) begin
            blk <= 1'b0;
            dst <= REG_A;
            bus_start({regs[REG_A], tmp[7:0]}, op == OP_OUT_IMM, 1'b1, regs[REG_A]);
            state <= S_IO;
          end
        end
        S_PUSH_H: begin
          if (bus_ack) begin
            bus_start(sp - TWO16, 1'b1, 1'b0, pc[7:0]);
            state <= S_PUSH_L;
          end
        end
        S_PUSH_L: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            sp      <= sp - TWO16;
            pc      <= tmp;
            state   <= S_NEXT;
          end
        end
        S_POP_L: begin
          if (bus_ack) begin
            tmp[7:0] <= bus_rdata;
            bus_start(sp + ONE16, 1'b0, 1'b0, ZERO8);
            state <= S_POP_H;
          end
        end
        S_POP_H: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            pc      <= {bus_rdata, tmp[7:0]};
            sp      <= sp + TWO16;
            state   <= S_NEXT;
          end
        end
        S_IO: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            state   <= S_NEXT;
            if (blk && !op[BLK_OUT_BIT]) begin
              bus_start(pointer_pair, 1'b1, 1'b0, bus_rdata);
              state <= S_MEM;
            end else if (blk) begin
              blk_finish();
            end else if (!bus_we && dst != REG_MEM) begin
              regs[dst] <= bus_rdata;
            end
          end
        end
        S_MEM: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            if (op[BLK_OUT_BIT]) begin
              bus_start({regs[REG_B], regs[REG_C]}, 1'b1, 1'b1, bus_rdata);
              state <= S_IO;
            end else begin
              blk_finish();
            end
          end
        end
        default: state <= S_NEXT;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_call_taken;
    state == S_EXEC && (op == OP_CALL ||
      ((op & MASK_CC) == PAT_CALLCC && cond_ok(op[5:3])));
  endsequence
  sequence s_push_high;
    state == S_PUSH_H && bus_we && bus_addr == sp - ONE16 && bus_wdata == pc[15:8];
  endsequence

  property p_call_push;
    s_call_taken |=> s_push_high;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_push_low;
    (state == S_PUSH_H && bus_ack) |=>
      state == S_PUSH_L && bus_addr == $past(bus_addr) - ONE16 && bus_wdata == pc[7:0];
  endproperty
  a_push_low: assert property (p_push_low) else $error("push order wrong");

  property p_call_target;
    (state == S_PUSH_L && bus_ack) |=> pc == $past(tmp) && sp == $past(sp) - TWO16;
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_pop_pc;
    (state == S_POP_H && bus_ack) |=>
      pc == {$past(bus_rdata), $past(tmp[7:0])} && sp == $past(sp) + TWO16;
  endproperty
  a_pop_pc: assert property (p_pop_pc) else $error("pop into pc wrong");

  property p_ret_forms;
    (state == S_DEC && ed && (op == OP_MASKABLE_INTERRUPT_RETURN || op == OP_NMI_RETURN)) |=>
      state == S_POP_L && bus_req && !bus_we && bus_addr == sp;
  endproperty
  a_ret_forms: assert property (p_ret_forms) else $error("interrupt return wrong");

  property p_jp_indirect;
    (state == S_DEC && !ed && op == OP_JP_INDIRECT) |=>
      pc == ($past(idx) == IDX_X ? $past(index_reg_x) :
             $past(idx) == IDX_Y ? $past(index_reg_y) : $past(pointer_pair));
  endproperty
  a_jp_indirect: assert property (p_jp_indirect) else $error("indirect jump wrong");

  property p_count_down_branch;
    (state == S_EXEC && op == OP_COUNT_DOWN_BRANCH) |=> regs[REG_B] == $past(b_dec) &&
      pc == ($past(b_dec) != ZERO8 ? $past(pc) + $past(disp) : $past(pc));
  endproperty
  a_count_down_branch: assert property (p_count_down_branch) else $error("loop branch wrong");

  property p_rst;
    (state == S_DEC && !ed && (op & MASK_CC) == PAT_RST) |=>
      s_push_high ##0 tmp == {ZERO8, $past(op) & RST_TGT};
  endproperty
  a_rst: assert property (p_rst) else $error("restart target wrong");

  property p_io_addr;
    (state == S_IO && bus_req) |->
      bus_addr == (ed ? {regs[REG_B], regs[REG_C]} : {regs[REG_A], tmp[7:0]});
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("port address wrong");

  property p_blk_step;
    blk_end |=> regs[REG_B] == $past(b_dec) && pointer_pair == $past(pointer_pair_step) &&
      pc == (($past(op[BLK_REP_BIT]) && $past(b_dec) != ZERO8) ? $past(pc) - TWO16 : $past(pc));
  endproperty
  a_blk_step: assert property (p_blk_step) else $error("block step wrong");

  property p_jp_skip;
    (state == S_EXEC && (op & MASK_CC) == PAT_JPCC && !cond_ok(op[5:3])) |=> pc == $past(pc);
  endproperty
  a_jp_skip: assert property (p_jp_skip) else $error("untaken jump moved pc");
endmodule : cbx_core

// ### common/cbx_pkg.sv
package cbx_pkg;
  localparam int AW = 16;
  localparam int DW = 8;
  localparam int NREGS = 8;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'hffff;
  localparam logic [15:0] ONE16    = 16'h0001;
  localparam logic [15:0] TWO16    = 16'h0002;
  localparam logic [7:0]  ZERO8    = 8'h00;

  // Register file indices, in opcode field order.
  localparam logic [2:0] REG_B   = 3'h0;
  localparam logic [2:0] REG_C   = 3'h1;
  localparam logic [2:0] REG_H   = 3'h4;
  localparam logic [2:0] REG_L   = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A   = 3'h7;

  // Flag bit positions of the condition flags input.
  localparam int FLAG_C  = 0;
  localparam int FLAG_PV = 2;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_S  = 7;

  // Block transfer opcode fields.
  localparam int BLK_OUT_BIT  = 0;
  localparam int BLK_DOWN_BIT = 3;
  localparam int BLK_REP_BIT  = 4;

  localparam logic [1:0] IDX_NONE = 2'h0;
  localparam logic [1:0] IDX_X    = 2'h1;
  localparam logic [1:0] IDX_Y    = 2'h2;

  localparam logic [7:0] OP_JR      = 8'h18;
  localparam logic [7:0] OP_JP      = 8'hc3;
  localparam logic [7:0] OP_CALL    = 8'hcd;
  localparam logic [7:0] OP_RET     = 8'hc9;
  localparam logic [7:0] OP_IN_IMM  = 8'hdb;
  localparam logic [7:0] OP_OUT_IMM = 8'hd3;
  localparam logic [7:0] OP_ED      = 8'hed;
  localparam logic [7:0] OP_DD      = 8'hdd;
  localparam logic [7:0] OP_FD      = 8'hfd;

  // Loop, indirect jump and interrupt return opcodes.
  localparam logic [7:0] OP_COUNT_DOWN_BRANCH         = 8'h10;
  localparam logic [7:0] OP_JP_INDIRECT               = 8'he9;
  localparam logic [7:0] OP_MASKABLE_INTERRUPT_RETURN = 8'h4d;
  localparam logic [7:0] OP_NMI_RETURN                = 8'h45;

  localparam logic [7:0] MASK_CC    = 8'hc7;
  localparam logic [7:0] PAT_RETCC  = 8'hc0;
  localparam logic [7:0] PAT_JPCC   = 8'hc2;
  localparam logic [7:0] PAT_CALLCC = 8'hc4;
  localparam logic [7:0] PAT_RST    = 8'hc7;
  localparam logic [7:0] RST_TGT    = 8'h38;
  localparam logic [7:0] MASK_JRCC  = 8'he7;
  localparam logic [7:0] PAT_JRCC   = 8'h20;
  localparam logic [7:0] PAT_LDN    = 8'h06;
  localparam logic [7:0] MASK_LDNN  = 8'hcf;
  localparam logic [7:0] PAT_LDNN   = 8'h01;
  localparam logic [7:0] PAT_INC    = 8'h40;
  localparam logic [7:0] PAT_OUTC   = 8'h41;
  localparam logic [7:0] MASK_BLK   = 8'he6;
  localparam logic [7:0] PAT_BLK    = 8'ha2;

  typedef enum logic [3:0] {
    S_NEXT, S_FETCH, S_DEC, S_IMM, S_EXEC,
    S_PUSH_H, S_PUSH_L, S_POP_L, S_POP_H, S_IO, S_MEM
  } cbx_state_t;
endpackage : cbx_pkg

// ### verif/cbx_periph.sv
`timescale 1ns/1ps
// =====================================================================
// Memory and port peripherals on the far side of the system bus.
module cbx_periph (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   bus_req,
  input  wire logic                   bus_we,
  input  wire logic                   bus_io,
  input  wire logic [cbx_pkg::AW-1:0] bus_addr,
  input  wire logic [cbx_pkg::DW-1:0] bus_wdata,
  output logic                        bus_ack,
  output logic [cbx_pkg::DW-1:0]      bus_rdata,
  input  wire logic                   int_return_seen,
  input  wire logic [1:0]             wait_n
);
  import cbx_pkg::*;
  logic [7:0]  mem [65536];
  logic [25:0] log_q [$];
  logic [1:0]  cnt;
  logic [7:0]  io_seq;
  logic [7:0]  last_rd;
  logic [7:0]  rd_val;
  logic [7:0]  int_return_cnt;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end

  assign bus_ack = bus_req && (cnt >= wait_n);
  assign rd_val  = bus_io ? io_seq : mem[bus_addr];
  // A released data bus shows the inverse of its last value, never a stale copy.
  assign bus_rdata = bus_ack ? rd_val : ~last_rd;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) cnt <= 2'h0;
    else if (bus_ack || !bus_req) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      io_seq  <= 8'h80;
      last_rd <= 8'h00;
    end else if (bus_ack && !bus_we) begin
      last_rd <= rd_val;
      if (bus_io) io_seq <= io_seq + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) int_return_cnt <= 8'h00;
    else if (int_return_seen) int_return_cnt <= int_return_cnt + 8'h01;
  end

  // Every completed transfer is logged as {io, we, address, data}.
  always @(posedge mclk) begin
    if (bus_req && bus_ack) begin
      if (bus_we && !bus_io) mem[bus_addr] <= bus_wdata;
      log_q.push_back({bus_io, bus_we, bus_addr, bus_we ? bus_wdata : rd_val});
    end
  end
endmodule : cbx_periph

// ### verif/cbx_core_bench.sv
`timescale 1ns/1ps
module cbx_core_bench;
  import cbx_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        bus_req;
  logic        bus_we;
  logic        bus_io;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_ack;
  logic [7:0]  bus_rdata;
  logic [7:0]  flags;
  logic        int_return_seen;
  logic [1:0]  wait_n;
  int          n_mismatch;
  int          cmp_count;

  cbx_core u_cbx_core (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .bus_we(bus_we),
    .bus_io(bus_io), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .flags(flags), .int_return_seen(int_return_seen));
  cbx_periph u_cbx_periph (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .bus_we(bus_we),
    .bus_io(bus_io), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .int_return_seen(int_return_seen), .wait_n(wait_n));

  always #2 mclk = ~mclk;

  // =====================================================================
  // Helpers
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Kind: 0 memory read, 1 memory write, 2 port read, 3 port write.
  function automatic logic [25:0] tr(input logic [1:0] k, input logic [15:0] a,
                                     input logic [7:0] d);
    return {k, a, d};
  endfunction : tr

  function automatic logic [25:0] lg(input int i);
    return u_cbx_periph.log_q[i];
  endfunction : lg

  function automatic logic [25:0] fa(input int i);
    return u_cbx_periph.log_q[i] >> 8;
  endfunction : fa

  task automatic hold(input logic [1:0] w);
    @(posedge mclk);
    rstn   <= 1'b0;
    wait_n <= w;
    @(posedge mclk);
    u_cbx_periph.log_q.delete();
  endtask : hold

  task automatic load(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) u_cbx_periph.mem[a + 16'(i)] = b[i];
  endtask : load

  task automatic go(input int n);
    int k;
    k = 0;
    @(posedge mclk);
    rstn <= 1'b1;
    while (u_cbx_periph.log_q.size() < n && k < 8000) begin
      @(posedge mclk);
      k++;
    end
    if (u_cbx_periph.log_q.size() < n) begin
      n_mismatch++;
      $display("wrong value at %0t: transfer count stalled", $time);
      tally_and_finish();
    end
  endtask : go

  // =====================================================================
  // Scenarios
  task automatic t_call_ret();
    hold(2'h0);
    load(16'h0000, '{8'h31, 8'h00, 8'h20, 8'hcd, 8'h34, 8'h12, 8'hed, 8'h4d});
    load(16'h1234, '{8'hc9});
    load(16'h2000, '{8'h78, 8'h56, 8'h9a, 8'hbc});
    load(16'h5678, '{8'hed, 8'h45});
    go(20);
    chk(lg(4), tr(2'h0, 16'h0004, 8'h34));
    chk(lg(5), tr(2'h0, 16'h0005, 8'h12));
    chk(lg(6), tr(2'h1, 16'h1fff, 8'h00));
    chk(lg(7), tr(2'h1, 16'h1ffe, 8'h06));
    chk(fa(8), 16'h1234);
    chk(lg(9), tr(2'h0, 16'h1ffe, 8'h06));
    chk(lg(10), tr(2'h0, 16'h1fff, 8'h00));
    chk(fa(11), 16'h0006);
    chk(fa(15), 16'h5678);
    chk(fa(19), 16'hbc9a);
    chk(u_cbx_periph.int_return_cnt, 8'h01);
    $display("call and return test done, %0d mismatches", n_mismatch);
  endtask : t_call_ret

  task automatic t_restart();
    for (int t = 0; t < 8; t++) begin
      hold(2'h1);
      load(16'h0000, '{8'h31, 8'h00, 8'h20, 8'hc7 | 8'(t << 3)});
      go(7);
      chk(lg(4), tr(2'h1, 16'h1fff, 8'h00));
      chk(lg(5), tr(2'h1, 16'h1ffe, 8'h04));
      chk(fa(6), 16'(t * 8));
    end
    $display("restart test done, %0d mismatches", n_mismatch);
  endtask : t_restart

  task automatic t_jump_indirect();
    hold(2'h3);
    load(16'h0000, '{8'h21, 8'h21, 8'h43, 8'hdd, 8'h21, 8'h00, 8'h30,
                     8'hfd, 8'h21, 8'h00, 8'h50, 8'he9});
    load(16'h4321, '{8'hdd, 8'he9});
    load(16'h3000, '{8'hfd, 8'he9});
    go(17);
    chk(fa(12), 16'h4321);
    chk(fa(14), 16'h3000);
    chk(fa(16), 16'h5000);
    $display("indirect jump test done, %0d mismatches", n_mismatch);
  endtask : t_jump_indirect

  task automatic t_loop();
    hold(2'h0);
    flags <= 8'h40;
    load(16'h0000, '{8'h06, 8'h02, 8'h00, 8'h10, 8'hfd, 8'h20, 8'h7f, 8'h28, 8'h7f});
    go(13);
    chk(fa(5), 16'h0002);
    chk(fa(8), 16'h0005);
    chk(fa(10), 16'h0007);
    chk(fa(12), 16'h0088);
    flags <= 8'h00;
    $display("loop and relative test done, %0d mismatches", n_mismatch);
  endtask : t_loop

  task automatic t_ports();
    hold(2'h2);
    load(16'h0000, '{8'h3e, 8'ha5, 8'hd3, 8'h3c, 8'hdb, 8'h77, 8'h01, 8'h34,
                     8'h12, 8'hed, 8'h79, 8'hed, 8'h50, 8'hed, 8'h51});
    go(20);
    chk(lg(4), tr(2'h3, 16'ha53c, 8'ha5));
    chk(lg(7), tr(2'h2, 16'ha577, 8'h80));
    chk(lg(13), tr(2'h3, 16'h1234, 8'h80));
    chk(lg(16), tr(2'h2, 16'h1234, 8'h81));
    chk(lg(19), tr(2'h3, 16'h1234, 8'h81));
    $display("port test done, %0d mismatches", n_mismatch);
  endtask : t_ports

  task automatic t_block();
    logic [7:0]  ops [8] = '{8'ha2, 8'haa, 8'hb2, 8'hba, 8'ha3, 8'hab, 8'hb3, 8'hbb};
    logic [15:0] ptr;
    logic [7:0]  b;
    logic [7:0]  v;
    int          idx;
    for (int o = 0; o < 8; o++) begin
      hold(2'(o));
      load(16'h0000, '{8'h01, 8'h44, 8'h02, 8'h21, 8'h00, 8'h40, 8'hed, ops[o]});
      load(16'h3fff, '{8'h33, 8'h11, 8'h22});
      go(ops[o][4] ? 15 : 11);
      idx = 8;
      ptr = 16'h4000;
      b = 8'h02;
      for (int s = 0; s <= int'(ops[o][4]); s++) begin
        v = (ptr == 16'h4000) ? 8'h11 : ((ptr == 16'h4001) ? 8'h22 : 8'h33);
        if (ops[o][0]) begin
          chk(lg(idx), tr(2'h0, ptr, v));
          chk(lg(idx + 1), tr(2'h3, {b, 8'h44}, v));
        end else begin
          chk(lg(idx), tr(2'h2, {b, 8'h44}, 8'h80 + 8'(s)));
          chk(lg(idx + 1), tr(2'h1, ptr, 8'h80 + 8'(s)));
        end
        idx += 2;
        b = b - 8'h01;
        ptr = ops[o][3] ? ptr - 16'h0001 : ptr + 16'h0001;
        if (ops[o][4] && s == 0) begin
          chk(fa(idx), 16'h0006);
          idx += 2;
        end
      end
      chk(fa(idx), 16'h0008);
    end
    $display("block transfer test done, %0d mismatches", n_mismatch);
  endtask : t_block

  task automatic t_block_full();
    int          nw;
    logic [25:0] e;
    nw = 0;
    hold(2'h0);
    load(16'h0000, '{8'h01, 8'h44, 8'h00, 8'h21, 8'h00, 8'h40, 8'hed, 8'hb3});
    go(1031);
    for (int i = 0; i < 1031; i++) begin
      e = lg(i);
      nw += (e[25:24] == 2'h3) ? 1 : 0;
    end
    chk(26'(nw), 26'h100);
    chk(fa(9), {2'h3, 16'h0044});
    chk(fa(1029), {2'h3, 16'h0144});
    chk(fa(1030), 16'h0008);
    $display("full count block test done, %0d mismatches", n_mismatch);
  endtask : t_block_full

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    flags = 8'h00;
    wait_n = 2'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    t_call_ret();
    t_restart();
    t_jump_indirect();
    t_loop();
    t_ports();
    t_block();
    t_block_full();
    tally_and_finish();
  end
endmodule : cbx_core_bench
